//--- pkg/tsc_pkg.sv
/*
  shared constants for the time stamp counter: register map, switch codes,
  time base periods and sequencer layout.
  assumes a 50 MHz system clock and a 32-bit classic wishbone master.
*/
package tsc_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int CNT_W = 16;
  localparam int GROUPS = 2;
  localparam int GRP_W = 1;

  // byte offsets of the register words
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COUNT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0c;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_CAPT = 8'h14;
  localparam logic [7:0] REG_G0_ADDR = 8'h20;
  localparam logic [7:0] REG_G0_MASK = 8'h24;
  localparam logic [7:0] REG_G0_CFG = 8'h28;
  localparam logic [7:0] REG_G1_ADDR = 8'h30;
  localparam logic [7:0] REG_G1_MASK = 8'h34;
  localparam logic [7:0] REG_G1_CFG = 8'h38;
  localparam logic [7:0] GRP_STRIDE = 8'h10;

  // control register fields
  localparam int CTRL_SW_LSB = 0;
  localparam int CTRL_SW_W = 4;
  localparam int CTRL_MRST = 4;
  localparam int CTRL_SEQ_EN = 5;

  // group config fields
  localparam int CFG_FC_LSB = 0;
  localparam int CFG_FC_W = 3;
  localparam int CFG_FC_USE = 3;
  localparam int CFG_FC_NOT = 4;
  localparam int CFG_ADR_USE = 5;
  localparam int CFG_ADR_NOT = 6;
  localparam int CFG_TRIG = 7;
  localparam int CFG_TRACE = 8;
  localparam int CFG_JUMP = 9;
  localparam int CFG_JMP_LSB = 10;

  // interrupt status bits
  localparam int IRQ_OVF = 0;
  localparam int IRQ_TRACE = 1;
  localparam int IRQ_TRIG = 2;
  localparam int IRQ_W = 3;

  localparam logic [3:0] SW_RESET_MAX = 4'h4;
  localparam logic [3:0] SW_GATE_MIN = 4'h5;
  localparam logic [3:0] SW_GATE_MAX = 4'h9;
  localparam logic [3:0] SW_COUNT = 4'hf;

  // time base periods in ns per tick, positions 0..4 and 5..9 alike
  localparam int TB_NS_0 = 100;
  localparam int TB_NS_1 = 1_000;
  localparam int TB_NS_2 = 10_000;
  localparam int TB_NS_3 = 100_000;
  localparam int TB_NS_4 = 1_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int TB_CYC_0 = TB_NS_0 / CLK_NS;
  localparam int TB_CYC_1 = TB_NS_1 / CLK_NS;
  localparam int TB_CYC_2 = TB_NS_2 / CLK_NS;
  localparam int TB_CYC_3 = TB_NS_3 / CLK_NS;
  localparam int TB_CYC_4 = TB_NS_4 / CLK_NS;
  localparam int DIV_W = 16;

endpackage

//--- hdl/tsc_match.sv
/*
  one sequencer group comparator: optional address under mask, optional function
  code test, each with optional inversion, combined by and.
  assumes bus cycle inputs are already synchronised.
*/
`timescale 1ns/1ps
module tsc_match
  import tsc_pkg::*;
(
  // bus sample
  input wire logic [31:0] addr_i,
  input wire logic [2:0] fc_i,
  // group setup
  input wire logic [31:0] cmp_addr_i,
  input wire logic [31:0] cmp_mask_i,
  input wire logic [31:0] cfg_i,
  // result
  output logic hit_o
);

  logic adr_eq;
  logic fc_eq;
  logic adr_ok;
  logic fc_ok;

  assign adr_eq = ((addr_i ^ cmp_addr_i) & cmp_mask_i) == 32'h0;
  assign fc_eq = fc_i == cfg_i[CFG_FC_LSB +: CFG_FC_W];
  // unused term counts as true; not flips a used term
  assign adr_ok = !cfg_i[CFG_ADR_USE] | (adr_eq ^ cfg_i[CFG_ADR_NOT]); // [R11]
  assign fc_ok = !cfg_i[CFG_FC_USE] | (fc_eq ^ cfg_i[CFG_FC_NOT]); // [R11]
  assign hit_o = adr_ok & fc_ok;

endmodule

//--- hdl/tsc_top.sv
/*
  time stamp counter with a small two-group event sequencer and a wishbone
  register slave.
  assumes single clock clk_i, sync reset rst_i, and async pins for the two
  external triggers, manual reset button and the processor bus strobe.
*/
// The placing of the registers and the Wishbone register port were decided locally.
// What this block does
// R1 - in positions 0 to 4 any trigger clears the count, which then keeps counting ticks.
// R2 - in position F each rising sequencer trigger adds one and the time base is ignored.
// R3 - a wrap of the count lights a sticky overflow indicator.
// R4 - the external trigger pins act like the sequencer trigger but bypass its delay.
// R5 - there is one active high and one active low external trigger pin.
// R6 - the count is in units of the selected time base period.
// R7 - position 5 ticks every 0.1 microseconds.
// R8 - a trace action stores the current count with the traced bus cycle.
// R9 - in gated mode counting runs while the trigger is held and stops after it.
// R10 - each bus cycle the current group is checked and on a hit it triggers, traces or jumps.
// R11 - conditions test address and function code with and and not.
// R12 - software should press the manual reset before a counting measurement.
// R13 - in positions 5 to 9 the trigger enables counting instead of clearing.
// R14 - the sequencer samples the bus once per bus cycle.
// R15 - manual reset clears count and overflow whatever the switch.
`timescale 1ns/1ps
module tsc_top
  import tsc_pkg::*;
#(
  parameter int CW = CNT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic ext_trig_i,
  input wire logic ext_trig_n_i,
  input wire logic man_rst_i,
  input wire logic bus_as_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [2:0] bus_fc_i,
  // indicators and trace
  output logic overflow_o,
  output logic trigger_pulse_o,
  output logic trace_o,
  output logic [31:0] trace_addr_o,
  output logic [CW-1:0] trace_count_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [1:0] s_trig;
  logic [1:0] s_trig_n;
  logic [1:0] s_mrst;
  logic [1:0] s_as;
  logic as_d;
  logic [34:0] bus_s1;
  logic [34:0] bus_s2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_s1 <= '0;
      bus_s2 <= '0;
      s_trig <= 2'h0;
      s_trig_n <= 2'h3;
      s_mrst <= 2'h0;
      s_as <= 2'h0;
      as_d <= 1'b0;
    end else begin
      bus_s1 <= {bus_fc_i, bus_addr_i};
      bus_s2 <= bus_s1;
      s_trig <= {s_trig[0], ext_trig_i};
      s_trig_n <= {s_trig_n[0], ext_trig_n_i};
      s_mrst <= {s_mrst[0], man_rst_i};
      s_as <= {s_as[0], bus_as_i};
      as_d <= s_as[1];
    end
  end
  logic bus_cyc;
  logic ext_trig;
  assign bus_cyc = s_as[1] & !as_d; // [R14]
  assign ext_trig = s_trig[1] | !s_trig_n[1]; // [R5]

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl;
  logic [31:0] g_addr [GROUPS];
  logic [31:0] g_mask [GROUPS];
  logic [31:0] g_cfg [GROUPS];
  logic [IRQ_W-1:0] irq_st;
  logic [IRQ_W-1:0] irq_en;
  logic [CW-1:0] count;
  logic [CW-1:0] capt;
  logic [GRP_W-1:0] grp;
  logic wr;
  logic [3:0] sw;
  logic mrst_sw;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
  assign sw = ctrl[CTRL_SW_LSB +: CTRL_SW_W];

  function automatic logic [31:0] lanes(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 32'h0;
      irq_en <= '0;
    end else begin
      ctrl[CTRL_MRST] <= 1'b0;
      if (wr && wb_adr_i == REG_CTRL) begin
        ctrl <= lanes(ctrl, wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == REG_IRQ_EN && wb_sel_i[0]) begin
        irq_en <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end
  assign mrst_sw = ctrl[CTRL_MRST];

  for (genvar g = 0; g < GROUPS; g++) begin : g_reg
    localparam logic [7:0] BASE = REG_G0_ADDR + GRP_STRIDE * 8'(g);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        g_addr[g] <= 32'h0;
        g_mask[g] <= 32'h0;
        g_cfg[g] <= 32'h0;
      end else if (wr) begin
        if (wb_adr_i == BASE) begin
          g_addr[g] <= lanes(g_addr[g], wb_dat_i, wb_sel_i);
        end
        if (wb_adr_i == BASE + REG_G0_MASK - REG_G0_ADDR) begin
          g_mask[g] <= lanes(g_mask[g], wb_dat_i, wb_sel_i);
        end
        if (wb_adr_i == BASE + REG_G0_CFG - REG_G0_ADDR) begin
          g_cfg[g] <= lanes(g_cfg[g], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  // read mux and registered ack, one answer per request after one wait state
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    case (wb_adr_i)
      REG_CTRL: rdata = ctrl;
      REG_COUNT: rdata = 32'(count);
      REG_STATUS: rdata = 32'(irq_st);
      REG_IRQ_EN: rdata = 32'(irq_en);
      REG_CAPT: rdata = 32'(capt);
      REG_G0_ADDR: rdata = g_addr[0];
      REG_G0_MASK: rdata = g_mask[0];
      REG_G0_CFG: rdata = g_cfg[0];
      REG_G1_ADDR: rdata = g_addr[1];
      REG_G1_MASK: rdata = g_mask[1];
      REG_G1_CFG: rdata = g_cfg[1];
      default: rdata = 32'h0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & !wb_ack_o;
      wb_dat_o <= rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event sequencer
  logic [GROUPS-1:0] hit;
  for (genvar g = 0; g < GROUPS; g++) begin : g_cmp
    tsc_match u_match (
      .addr_i(bus_s2[31:0]),
      .fc_i(bus_s2[34:32]),
      .cmp_addr_i(g_addr[g]),
      .cmp_mask_i(g_mask[g]),
      .cfg_i(g_cfg[g]),
      .hit_o(hit[g])
    );
  end
  logic [31:0] cur_cfg;
  logic seq_hit;
  assign cur_cfg = g_cfg[grp];
  assign seq_hit = bus_cyc & hit[grp] & ctrl[CTRL_SEQ_EN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grp <= '0;
      trigger_pulse_o <= 1'b0;
      trace_o <= 1'b0;
    end else begin
      trace_o <= 1'b0;
      if (!ctrl[CTRL_SEQ_EN]) begin
        grp <= '0;
        trigger_pulse_o <= 1'b0;
      end else if (bus_cyc) begin
        // trigger level holds from the bus cycle that matched until the next bus cycle
        trigger_pulse_o <= seq_hit & cur_cfg[CFG_TRIG]; // [R10] [R9]
        trace_o <= seq_hit & cur_cfg[CFG_TRACE]; // [R10]
        if (seq_hit && cur_cfg[CFG_JUMP]) begin
          grp <= cur_cfg[CFG_JMP_LSB +: GRP_W]; // [R10]
        end
      end
    end
  end

  // trace capture of count with bus address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trace_addr_o <= 32'h0;
      trace_count_o <= '0;
      capt <= '0;
    end else if (seq_hit && cur_cfg[CFG_TRACE]) begin
      trace_addr_o <= bus_s2[31:0]; // [R8]
      trace_count_o <= count; // [R8]
      capt <= count; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time base divider; positions 5..9 mirror 0..4
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] div_max;
  logic tick;
  logic [3:0] tb_sel;
  assign tb_sel = (sw >= SW_GATE_MIN) ? sw - SW_GATE_MIN : sw;
  always_comb begin
    case (tb_sel)
      4'h0: div_max = DIV_W'(TB_CYC_0 - 1); // [R7] [R6]
      4'h1: div_max = DIV_W'(TB_CYC_1 - 1);
      4'h2: div_max = DIV_W'(TB_CYC_2 - 1);
      4'h3: div_max = DIV_W'(TB_CYC_3 - 1);
      4'h4: div_max = DIV_W'(TB_CYC_4 - 1);
      default: div_max = DIV_W'(TB_CYC_4 - 1);
    endcase
  end
  // a switch to a shorter base may leave div above the new limit
  assign tick = div >= div_max;
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter
  logic trig_any;
  logic trig_d;
  logic mrst;
  logic mode_reset;
  logic mode_gate;
  logic mode_count;
  logic inc;
  assign trig_any = trigger_pulse_o | ext_trig; // [R4]
  assign mrst = s_mrst[1] | mrst_sw;
  assign mode_reset = sw <= SW_RESET_MAX;
  assign mode_gate = sw >= SW_GATE_MIN && sw <= SW_GATE_MAX;
  assign mode_count = sw == SW_COUNT;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_d <= 1'b0;
    end else begin
      trig_d <= trig_any;
    end
  end
  always_comb begin
    inc = 1'b0;
    if (mode_count) begin
      inc = trig_any & !trig_d; // [R2]
    end else if (mode_gate) begin
      inc = tick & trig_any; // [R13] [R9]
    end else if (mode_reset) begin
      inc = tick; // [R1] [R6]
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || mrst) begin
      count <= '0; // [R15]
      overflow_o <= 1'b0; // [R15]
    end else if (mode_reset && trig_any) begin
      count <= '0; // [R1] [R4]
    end else if (inc) begin
      count <= count + 1'b1;
      if (&count) begin
        overflow_o <= 1'b1; // [R3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over clear
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  assign ev[IRQ_OVF] = inc & (&count) & !mrst & !(mode_reset & trig_any);
  assign ev[IRQ_TRACE] = seq_hit & cur_cfg[CFG_TRACE];
  assign ev[IRQ_TRIG] = trig_any & !trig_d;
  assign clr = (wr && wb_adr_i == REG_IRQ_CLR && wb_sel_i[0]) ?
               wb_dat_i[IRQ_W-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_st <= (irq_st & ~clr) | ev;
      irq_o <= |(((irq_st & ~clr) | ev) & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  reset_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mrst |=> count == '0 && !overflow_o) // [R15]
    else $error("manual reset did not clear");
  trig_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reset && trig_any && !mrst |=> count == '0) // [R1]
    else $error("trigger did not clear count");
  ext_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reset && !s_trig_n[1] && !mrst |=> count == '0) // [R4]
    else $error("low trigger pin ignored");
  edge_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_count && $rose(trig_any) && !mrst && !$changed(sw)
    |=> count == $past(count) + 1'b1) // [R2]
    else $error("pulse not counted");
  gate_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_gate && !trig_any && !mrst |=> $stable(count)) // [R13]
    else $error("counter ran without gate");
  overflow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    inc && (&count) && !mrst && !(mode_reset && trig_any)
    |=> overflow_o && count == '0) // [R3]
    else $error("overflow not flagged");
  trace_val_a: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_hit && cur_cfg[CFG_TRACE] |=> trace_o &&
    trace_count_o == $past(count)) // [R8]
    else $error("trace lost count");
  tick_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sw == SW_GATE_MIN && tick && !$changed(sw) |=> !tick [*4]) // [R7]
    else $error("time base too fast");
  seq_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus_cyc && ctrl[CTRL_SEQ_EN] |=> $stable(grp)) // [R14]
    else $error("group moved between bus cycles");
  reset_cov_c: cover property (@(posedge clk_i) mode_reset && trig_any);
  gate_cov_c: cover property (@(posedge clk_i) mode_gate && inc);
  count_cov_c: cover property (@(posedge clk_i) mode_count && inc);
  jump_cov_c: cover property (@(posedge clk_i) seq_hit && cur_cfg[CFG_JUMP]);

endmodule

//--- dv/tsc_far_model.sv
/*
  far side model: processor bus cycles seen by the sequencer and the
  target trigger lines.
  assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
module tsc_far_model (
  // clock
  input wire logic clk_i,
  // bus sample
  output logic bus_as_o,
  output logic [31:0] bus_addr_o,
  output logic [2:0] bus_fc_o,
  // target trigger lines
  output logic trig_o,
  output logic trig_n_o
);
  initial begin
    bus_as_o = 1'b0;
    bus_addr_o = 32'h0;
    bus_fc_o = 3'h0;
    trig_o = 1'b0;
    trig_n_o = 1'b1;
  end

  // one strobe per bus cycle, sample set a clock before the strobe and changed as it falls
  task automatic cyc(input logic [31:0] a, input logic [2:0] f);
    @(posedge clk_i);
    bus_addr_o <= a;
    bus_fc_o <= f;
    @(posedge clk_i);
    bus_as_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    bus_as_o <= 1'b0;
    bus_addr_o <= ~a;
    bus_fc_o <= ~f;
    repeat (4) @(posedge clk_i);
  endtask

  // w clocks on the high pin (p=0) or the low pin (p=1)
  task automatic pulse(input bit p, input int w, input bit keep);
    @(posedge clk_i);
    if (p) trig_n_o <= 1'b0;
    else trig_o <= 1'b1;
    repeat (w) @(posedge clk_i);
    if (!keep) rel();
    repeat (8) @(posedge clk_i);
  endtask

  task automatic rel();
    trig_o <= 1'b0;
    trig_n_o <= 1'b1;
  endtask
endmodule

//--- dv/tsc_top_tb_top.sv
/*
  bench for the time stamp counter: switch rows in one loop, then
  sequencer, overflow, interrupt and manual reset cases.
  assumes the far side model drives bus and trigger pins.
*/
`timescale 1ns/1ps
module tsc_top_tb_top
  import tsc_pkg::*;
;
  typedef struct {
    logic [3:0] sw;
    bit p;
    int w;
    int n;
    bit keep;
    logic [7:0] exp;
  } tsc_row_t;

  logic clk, rst, cyc, stb, we, ack, trig, trig_n, mrst, as;
  logic ovf, tp, tr, irq;
  logic [7:0] adr, tcnt;
  logic [3:0] sel;
  logic [31:0] wd, dat_o, rq, baddr, taddr;
  logic [2:0] fc;
  int error_cnt = 0;
  int checks_done = 0;
  int n_tr = 0;

  tsc_row_t rows[14] = '{
    '{4'h0, 0, 20, 1, 1, 0}, '{4'h1, 1, 20, 1, 1, 0},
    '{4'h2, 0, 20, 1, 1, 0}, '{4'h3, 1, 20, 1, 1, 0},
    '{4'h4, 0, 20, 1, 1, 0}, '{4'h5, 0, 500, 1, 0, 100},
    '{4'h6, 1, 500, 1, 0, 10}, '{4'h7, 0, 500, 1, 0, 1},
    '{4'h8, 1, 500, 1, 0, 0}, '{4'h9, 0, 500, 1, 0, 0},
    '{4'hf, 0, 4, 3, 0, 3}, '{4'hf, 1, 4, 5, 0, 5},
    '{4'ha, 0, 4, 3, 0, 0}, '{4'he, 1, 4, 3, 0, 0}};
  logic [31:0] sa[5] = '{32'h1100, 32'h1104, 32'h1100, 32'h0, 32'h1100};
  logic [2:0] sf[5] = '{3'h5, 3'h6, 3'h6, 3'h7, 3'h6};
  logic st[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  tsc_top #(.CW(8)) i_tsc_top (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_trig_i(trig),
    .ext_trig_n_i(trig_n), .man_rst_i(mrst), .bus_as_i(as),
    .bus_addr_i(baddr), .bus_fc_i(fc), .overflow_o(ovf),
    .trigger_pulse_o(tp), .trace_o(tr), .trace_addr_o(taddr),
    .trace_count_o(tcnt), .irq_o(irq));

  tsc_far_model i_tsc_far_model (
    .clk_i(clk), .bus_as_o(as), .bus_addr_o(baddr), .bus_fc_o(fc),
    .trig_o(trig), .trig_n_o(trig_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (tr === 1'b1) n_tr <= n_tr + 1;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rq = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'hf;
    wd = 32'h0;
    mrst = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(ovf, 1'b0);
    chk(irq, 1'b0);
    chk(tp, 1'b0);
    chk(tr, 1'b0);
    wb(0, REG_COUNT, 0);
    chk(rq, 32'h0);
    wb(0, 8'h3c, 0);
    chk(rq, 32'h0);
    wb(0, REG_IRQ_CLR, 0);
    chk(rq, 32'h0);
    // switch rows, each after a manual reset
    foreach (rows[i]) begin
      wb(1, REG_CTRL, 32'h10 | rows[i].sw);
      repeat (rows[i].n) i_tsc_far_model.pulse(rows[i].p, rows[i].w,
                                                rows[i].keep);
      wb(0, REG_COUNT, 0);
      chk(rq[7:0], rows[i].exp);
      i_tsc_far_model.rel();
    end
    // sequencer: fc qualified groups, trigger, trace and jump
    wb(1, REG_G0_ADDR, 32'h1100);
    wb(1, REG_G0_MASK, 32'hffff_fff0);
    wb(1, REG_G0_CFG, 32'h6ae);
    wb(1, REG_G1_CFG, 32'h30f);
    wb(1, REG_IRQ_CLR, 32'h7);
    wb(1, REG_CTRL, 32'h3f);
    foreach (sa[i]) begin
      i_tsc_far_model.cyc(sa[i], sf[i]);
      chk(tp, st[i]);
    end
    chk(n_tr, 1);
    chk(taddr, 32'h0);
    chk(tcnt, 8'h1);
    wb(0, REG_CAPT, 0);
    chk(rq[7:0], 8'h1);
    wb(0, REG_COUNT, 0);
    chk(rq[7:0], 8'h2);
    wb(0, REG_STATUS, 0);
    chk(rq[2:0], 3'h6);
    // wrap, overflow interrupt, then the manual reset pin
    wb(1, REG_IRQ_CLR, 32'h7);
    wb(1, REG_IRQ_EN, 32'h1);
    wb(1, REG_CTRL, 32'h1f);
    chk(irq, 1'b0);
    repeat (256) i_tsc_far_model.pulse(0, 4, 0);
    chk(ovf, 1'b1);
    chk(irq, 1'b1);
    wb(0, REG_COUNT, 0);
    chk(rq[7:0], 8'h0);
    wb(1, REG_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    chk(ovf, 1'b1);
    repeat (3) i_tsc_far_model.pulse(0, 4, 0);
    mrst <= 1'b1;
    repeat (6) @(posedge clk);
    mrst <= 1'b0;
    repeat (6) @(posedge clk);
    chk(ovf, 1'b0);
    wb(0, REG_COUNT, 0);
    chk(rq[7:0], 8'h0);
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
